// ---- drfm_pkg.sv ----
// drfm_pkg: constants and types for the dram refresh-mode controller
// assumes a single 25 MHz clock; all times are rounded to whole cycles
package drfm_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 9;
	localparam int ROW_COUNT = 2048;
	localparam int INIT_CYCLES = 8;
	// least times, rounded up to whole cycles
	localparam int STORE_SETUP_BEFORE_ROW_FALL_NS = 10;
	localparam int STORE_HOLD_AFTER_ROW_FALL_NS = 10;
	localparam int ROW_PRECHARGE_MIN_NS = 40;
	localparam int ROW_ACTIVE_MIN_NS = 60;
	localparam int SETUP_CYC = (STORE_SETUP_BEFORE_ROW_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (STORE_HOLD_AFTER_ROW_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECH_CYC = (ROW_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACTIVE_CYC = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// distributed refresh interval, a longest time: rounded down
	localparam int REFRESH_INTERVAL_PS = 15600000 / 1000;
	localparam int REFRESH_INTERVAL_NS = 15600;
	localparam int REFRESH_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam logic [3:0] TIMER_RST = 4'h0;
	localparam logic [ADDR_W-1:0] ROW_RST = 11'h000;

	// controller cycle kinds and states
	typedef enum logic [1:0] {DRFM_REF_ROW_ONLY, DRFM_REF_COUNTER, DRFM_REF_HIDDEN} drfm_mode_e;
	typedef enum {
		DRFM_IDLE,
		DRFM_INIT_CAS,
		DRFM_INIT_RAS,
		DRFM_INIT_END,
		DRFM_RO_ROW,
		DRFM_RO_END,
		DRFM_CB_CAS,
		DRFM_CB_RAS,
		DRFM_CB_END,
		DRFM_HID_PRE,
		DRFM_HID_RAS,
		DRFM_PRECH
	} drfm_state_e;
endpackage : drfm_pkg

// ---- drfm_ctrl.sv ----
// drfm_ctrl: host-side refresh controller that drives dram strobes and address
// assumes an external access engine owns the bus when refresh is not active
// Summary of operation
// - row-only refresh: row strobe low with row address, column strobe held high
// - keep own row counter, step it each row-only refresh, wrap after last row
// - store strobe held high around row strobe fall in counter refresh
// - hidden refresh: keep column strobe low, raise row strobe for precharge, relower
// - store strobe high around row fall in hidden refresh too
// - counter test only after at least 8 counter refresh init cycles
// - counter test order: zeros, test reads, test writes, read ones, complement
// - request one distributed refresh about every 15.6 microseconds
// - store strobe setup and hold around row fall at least 10 ns each
`timescale 1ns/100ps
module drfm_ctrl
	import drfm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// refresh requests from the system and status back to it
	input wire logic start_i,
	input wire logic [1:0] mode_i,
	input wire logic access_open_i,
	output logic busy_o,
	output logic done_o,
	output logic init_done_o,
	output logic refresh_due_o,
	// dram pins
	output logic row_strobe_n_o,
	output logic column_strobe_n_o,
	output logic store_strobe_n_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic addr_oe_o
);
	// sequencer state, timers and counters
	drfm_state_e state_q;
	drfm_state_e state_d;
	logic [3:0] timer_q;
	logic [3:0] init_cnt_q;
	logic [ADDR_W-1:0] row_q;
	logic [15:0] tick_q;
	logic req_q;
	logic take_w;
	logic [1:0] pins_d;

	// pins decoded from state; store strobe is never lowered by refresh
	function automatic logic [1:0] strobes(input drfm_state_e s);
		case (s)
			DRFM_INIT_CAS, DRFM_CB_CAS, DRFM_HID_PRE: strobes = 2'b10; // row hi, col lo
			DRFM_INIT_RAS, DRFM_CB_RAS, DRFM_HID_RAS: strobes = 2'b00;
			DRFM_RO_ROW: strobes = 2'b01;
			default: strobes = 2'b11;
		endcase
	endfunction : strobes

	// a request is taken only in idle once the wake-up cycles are through;
	// a start seen while busy is dropped, so the system must hold or retry it
	assign take_w = (state_q == DRFM_IDLE) && start_i && init_done_o;

	// sequencing of the refresh cycles
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			DRFM_IDLE:
			begin
				if (init_cnt_q < 4'(INIT_CYCLES))
					state_d = DRFM_INIT_CAS;
				else if (start_i)
				begin
					if (mode_i == 2'(DRFM_REF_ROW_ONLY))
						state_d = DRFM_RO_ROW;
					else if (mode_i == 2'(DRFM_REF_HIDDEN) && access_open_i)
						state_d = DRFM_HID_PRE;
					else
						state_d = DRFM_CB_CAS;
				end
			end
			// column strobe leads the row strobe fall by at least one whole cycle
			DRFM_INIT_CAS, DRFM_CB_CAS:
			begin
				if (timer_q >= 4'(SETUP_CYC))
					state_d = (state_q == DRFM_INIT_CAS) ? DRFM_INIT_RAS : DRFM_CB_RAS;
			end
			// row strobe stays low for the active time and the store hold time
			DRFM_INIT_RAS, DRFM_CB_RAS, DRFM_HID_RAS, DRFM_RO_ROW:
			begin
				if (timer_q >= 4'(ACTIVE_CYC) && timer_q >= 4'(HOLD_CYC))
					state_d = DRFM_PRECH;
			end
			// row strobe high for precharge while the column strobe stays low
			DRFM_HID_PRE:
			begin
				if (timer_q >= 4'(PRECH_CYC))
					state_d = DRFM_HID_RAS;
			end
			DRFM_PRECH:
			begin
				if (timer_q >= 4'(PRECH_CYC))
					state_d = DRFM_IDLE;
			end
			default: state_d = DRFM_IDLE;
		endcase
	end

	// strobe levels for the coming state, decoded once for both pins
	assign pins_d = strobes(state_d);

	// state register; pins follow it from the same edge, so timing counts whole cycles
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= DRFM_IDLE;
		else
			state_q <= state_d;
	end

	// per-state timer, cleared on each change of state; saturates so a long idle cannot wrap
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_q <= TIMER_RST;
		else if (state_d != state_q)
			timer_q <= TIMER_RST;
		else if (timer_q != 4'hF)
			timer_q <= timer_q + 4'h1;
	end

	// init counter stops at the required number of counter cycles
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			init_cnt_q <= 4'h0;
		else if (state_q == DRFM_INIT_RAS && state_d == DRFM_PRECH)
			init_cnt_q <= init_cnt_q + 4'h1;
	end

	// own row counter for row-only refresh, wraps naturally at 2048
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			row_q <= ROW_RST;
		else if (state_q == DRFM_RO_ROW && state_d == DRFM_PRECH)
			row_q <= row_q + 11'h001;
	end

	// marks a cycle that the system asked for, so wake-up cycles raise no done pulse
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			req_q <= 1'b0;
		else if (take_w)
			req_q <= 1'b1;
		else if (state_q == DRFM_PRECH && state_d == DRFM_IDLE)
			req_q <= 1'b0;
	end

	// distributed refresh tick; a missed tick stays pending until served
	// rounded down to whole cycles, so the tick never comes later than the interval
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tick_q <= 16'h0000;
		else if (tick_q >= 16'(REFRESH_CYC - 1))
			tick_q <= 16'h0000;
		else
			tick_q <= tick_q + 16'h0001;
	end

	// pending flag: a tick in the cycle a start is taken keeps it set
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			refresh_due_o <= 1'b0;
		else if (tick_q >= 16'(REFRESH_CYC - 1))
			refresh_due_o <= 1'b1; // set wins over clear
		else if (take_w)
			refresh_due_o <= 1'b0;
	end

	// registered pin drive; address driven in every refresh state, carrying a row only in row-only refresh
	// registering the pins keeps decode glitches off the strobes
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
		begin
			row_strobe_n_o <= 1'b1;
			column_strobe_n_o <= 1'b1;
			store_strobe_n_o <= 1'b1;
			addr_o <= ROW_RST;
			addr_oe_o <= 1'b0;
		end
		else
		begin
			row_strobe_n_o <= pins_d[1];
			column_strobe_n_o <= pins_d[0];
			store_strobe_n_o <= 1'b1;
			addr_o <= (state_d == DRFM_RO_ROW) ? row_q : ROW_RST;
			addr_oe_o <= (state_d != DRFM_IDLE);
		end

	// status to the system; done only for cycles that were requested
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			done_o <= 1'b0;
		else
			done_o <= (state_q == DRFM_PRECH && state_d == DRFM_IDLE && req_q);
	end

	// the access engine may start the counter test only once busy drops after wake-up
	assign init_done_o = (init_cnt_q >= 4'(INIT_CYCLES));
	assign busy_o = (state_q != DRFM_IDLE) || !init_done_o;
endmodule : drfm_ctrl

// ---- drfm_ctrl_checker.sv ----
// drfm_ctrl_checker: strobe order and timing checks on the controller pins
// assumes it is bound onto drfm_ctrl and samples on clk_i
`timescale 1ns/100ps
module drfm_ctrl_checker
	import drfm_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic init_done_o,
	input wire logic refresh_due_o,
	input wire logic row_strobe_n_o,
	input wire logic column_strobe_n_o,
	input wire logic store_strobe_n_o,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic addr_oe_o
);
	logic [3:0] cbr_q;
	logic [ADDR_W-1:0] last_q;
	logic seen_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ro;
		$fell(row_strobe_n_o) && column_strobe_n_o;
	endsequence
	sequence s_cbr;
		$fell(row_strobe_n_o) && !column_strobe_n_o;
	endsequence
	// saturating at eight keeps the helper small
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) cbr_q <= 4'h0;
		else if ($fell(row_strobe_n_o) && !column_strobe_n_o && cbr_q != 4'h8) cbr_q <= cbr_q + 4'h1;
	// remember the last row-only address to check the step
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) seen_q <= 1'b0;
		else if ($fell(row_strobe_n_o) && column_strobe_n_o) seen_q <= 1'b1;
	always_ff @(posedge clk_i)
		if ($fell(row_strobe_n_o) && column_strobe_n_o) last_q <= addr_o;
	AST_STORE_HIGH: assert property (store_strobe_n_o)
		else $error("store strobe driven low");
	AST_CBR_ORDER: assert property (s_cbr |-> !$past(column_strobe_n_o))
		else $error("column strobe not low before row fall");
	AST_PRECH_MIN: assert property ($rose(row_strobe_n_o) |=> row_strobe_n_o)
		else $error("row strobe precharge too short");
	AST_RO_COL_HIGH: assert property (s_ro |-> column_strobe_n_o [*2])
		else $error("column strobe dropped in row-only refresh");
	AST_RO_OE: assert property (s_ro |-> addr_oe_o)
		else $error("row address not driven");
	AST_ROW_ACTIVE: assert property ($fell(row_strobe_n_o) |=> !row_strobe_n_o)
		else $error("row strobe pulse too short");
	AST_ROW_STEP: assert property (s_ro and seen_q |-> addr_o == last_q + 11'h001)
		else $error("row counter did not step by one");
	AST_INIT_COUNT: assert property (init_done_o |-> cbr_q == 4'h8)
		else $error("init done before eight counter cycles");
	AST_DUE_STICKY: assert property (refresh_due_o && !start_i |=> refresh_due_o)
		else $error("refresh due dropped without start");
endmodule : drfm_ctrl_checker

// ---- drfm_dram_model.sv ----
// drfm_dram_model: behavioural refresh side of the dram, strobes and address only
// assumes strobes come from drfm_ctrl; data pins are not modelled
`timescale 1ns/100ps
module drfm_dram_model
	import drfm_pkg::*;
(
	// dram pins
	input wire logic row_strobe_n_i,
	input wire logic column_strobe_n_i,
	input wire logic store_strobe_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	// observation
	output logic [ADDR_W-1:0] counter_o = 11'h000,
	output logic [ADDR_W-1:0] last_row_o = 11'h000,
	output logic test_mode_o = 1'b0
);
	// column order at the row fall picks the cycle kind; address ignored for counter cycles
	always @(negedge row_strobe_n_i)
		if (!column_strobe_n_i)
		begin
			counter_o <= counter_o + 11'h001;
			test_mode_o <= test_mode_o | !store_strobe_n_i;
		end
		else
			last_row_o <= addr_i;
endmodule : drfm_dram_model

// ---- drfm_ctrl_tb_top.sv ----
// drfm_ctrl_tb_top: directed refresh scenarios against the dram model
// assumes drfm_pkg, drfm_ctrl, checker and model are compiled first
`timescale 1ns/100ps
module drfm_ctrl_tb_top;
	import drfm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic start_i = 1'b0;
	logic [1:0] mode_i = 2'h0;
	logic access_open_i = 1'b0;
	logic busy_o, done_o, init_done_o, refresh_due_o, addr_oe_o;
	logic row_strobe_n_o, column_strobe_n_o, store_strobe_n_o, test_mode;
	logic [ADDR_W-1:0] addr_o, ctr, last_row;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	drfm_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i),
		.access_open_i(access_open_i), .busy_o(busy_o), .done_o(done_o),
		.init_done_o(init_done_o), .refresh_due_o(refresh_due_o),
		.row_strobe_n_o(row_strobe_n_o), .column_strobe_n_o(column_strobe_n_o),
		.store_strobe_n_o(store_strobe_n_o), .addr_o(addr_o), .addr_oe_o(addr_oe_o));
	drfm_dram_model MEM (.row_strobe_n_i(row_strobe_n_o), .column_strobe_n_i(column_strobe_n_o),
		.store_strobe_n_i(store_strobe_n_o), .addr_i(addr_o), .counter_o(ctr),
		.last_row_o(last_row), .test_mode_o(test_mode));
	initial forever #20 clk_i = ~clk_i;
	// the whole run needs under 1500 cycles; a hang is cut at 6000
	always @(posedge clk_i)
	begin
		cycles = cycles + 1;
		if (cycles == 6000)
		begin
			miscompares = miscompares + 1;
			close_out();
		end
	end
	task automatic cmp(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// start is raised only once the controller is idle, since a busy one drops it
	task automatic refresh(input logic [1:0] mode, input logic open);
		int n;
		@(negedge clk_i);
		for (n = 0; n < 40 && busy_o !== 1'b0; n++) @(negedge clk_i);
		mode_i = mode;
		access_open_i = open;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		for (n = 0; n < 40 && done_o !== 1'b1; n++) @(negedge clk_i);
		cmp({10'h000, done_o}, 11'h001);
		access_open_i = 1'b0;
	endtask : refresh
	// which picks the flag: 0 init done, 1 refresh due
	task automatic wait_flag(input int which);
		int n;
		for (n = 0; n < 500 && (which == 0 ? init_done_o : refresh_due_o) !== 1'b1; n++)
			@(negedge clk_i);
		cmp({10'h000, (which == 0 ? init_done_o : refresh_due_o)}, 11'h001);
	endtask : wait_flag
	task automatic t_init;
		cmp({10'h000, busy_o}, 11'h001);
		wait_flag(0);
		cmp(ctr, 11'h008);
	endtask : t_init
	task automatic t_modes;
		refresh(2'h0, 1'b0);
		cmp(last_row, 11'h000);
		refresh(2'h0, 1'b0);
		cmp(last_row, 11'h001);
		cmp(ctr, 11'h008);
		refresh(2'h1, 1'b0);
		refresh(2'h1, 1'b0);
		cmp(ctr, 11'h00a);
		refresh(2'h2, 1'b1);
		refresh(2'h2, 1'b0);
		cmp(ctr, 11'h00c);
		cmp({10'h000, test_mode}, 11'h000);
	endtask : t_modes
	task automatic t_due;
		wait_flag(1);
		refresh(2'h0, 1'b0);
		cmp(last_row, 11'h002);
		cmp({10'h000, refresh_due_o}, 11'h000);
	endtask : t_due
	task automatic close_out;
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		t_init();
		t_modes();
		t_due();
		close_out();
	end
endmodule : drfm_ctrl_tb_top
bind drfm_ctrl drfm_ctrl_checker CHK (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
	.init_done_o(init_done_o), .refresh_due_o(refresh_due_o), .row_strobe_n_o(row_strobe_n_o),
	.column_strobe_n_o(column_strobe_n_o), .store_strobe_n_o(store_strobe_n_o),
	.addr_o(addr_o), .addr_oe_o(addr_oe_o));
